// File: logic/usage_counters_event_log.sv
// Usage counters, event ring log, built-in clock and actual-value output code.
// Assumes nonvolatile backing of the state is handled by the surrounding storage
// controller, which restores the cycle and hours counters through the preload port at power-up.
`timescale 1ns/100ps

module usage_counters_event_log
   import usage_log_pkg::*;
#(
   parameter longint unsigned STEP_CYC = HOUR_STEP_CYC,
   parameter int unsigned TICK_CYC = SEC_CYC
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rstn,
   // Nonvolatile restore at power-up
   input wire logic i_nv_load,
   input wire logic [CNT_W-1:0] i_nv_cycles,
   input wire logic [CNT_W-1:0] i_nv_hours,
   // Process inputs (pins, synchronised here)
   input wire logic i_start_sealing_bit,
   input wire logic i_auto_zero_calibration,
   // Control logic inputs (same clock)
   input wire logic [TEMP_W-1:0] i_actual_temp,
   input wire logic i_range_hi,
   input wire logic i_fault,
   input wire logic [DAC_W-1:0] i_fault_level,
   input wire logic i_err_strobe,
   input wire logic [CODE_W-1:0] i_err_code,
   input wire logic [CHAN_W-1:0] i_chan,
   // Clock requests
   input wire logic i_clk_req_valid,
   input wire clock_req_s i_clk_req,
   // Log readout
   input wire logic [LOG_IDX_W-1:0] i_rd_age,
   // Outputs
   output logic [DAC_W-1:0] o_dac_code,
   output logic [CNT_W-1:0] o_cycles,
   output logic [CNT_W-1:0] o_hours,
   output logic [TIME_W-1:0] o_time,
   output logic o_time_valid,
   output logic o_clk_req_reject,
   output log_entry_s o_rd_entry,
   output logic [LOG_IDX_W-1:0] o_log_count
);

   // =====================================================================
   // State
   // =====================================================================
   typedef struct packed {
      logic [1:0] st_sync;
      logic [1:0] az_sync;
      logic st_prev;
      logic az_prev;
      logic [CNT_W-1:0] cycles;
      logic [CNT_W-1:0] hours;
      logic [63:0] step_cnt;
      logic [31:0] tick_cnt;
      logic [TIME_W-1:0] now;
      logic now_valid;
      logic [LOG_IDX_W-1:0] wr_idx;
      logic [LOG_IDX_W-1:0] count;
      logic [DAC_W-1:0] dac;
      logic reject;
      log_entry_s rd;
   } state_s;

   state_s s_q;
   state_s s_d;
   log_entry_s mem_q [LOG_DEPTH];
   logic log_we;
   log_entry_s log_wdata;

   // Steps a ring index back by n plus one, so age zero lands on the newest entry.
   // The sum is kept one bit wider so the wrap test cannot overflow.
   function automatic logic [LOG_IDX_W-1:0] ring_back(input logic [LOG_IDX_W-1:0] idx,
                                                       input logic [LOG_IDX_W-1:0] n);
      logic [LOG_IDX_W:0] t;
      t = {1'b0, idx} + LOG_IDX_W'(LOG_DEPTH) - {1'b0, n} - 1'b1;
      if (t >= (LOG_IDX_W+1)'(LOG_DEPTH)) begin
         t = t - (LOG_IDX_W+1)'(LOG_DEPTH);
      end
      return t[LOG_IDX_W-1:0];
   endfunction

   // =====================================================================
   // Next-state logic
   // =====================================================================
   // Scaling uses a divide by the range so the code reaches exactly full scale.
   always_comb begin
      logic [TEMP_W-1:0] range;
      logic [TEMP_W+DAC_W-1:0] prod;
      logic st_rise;
      logic az_rise;
      range = '0;
      prod = '0;
      st_rise = s_q.st_sync[1] & ~s_q.st_prev;
      az_rise = s_q.az_sync[1] & ~s_q.az_prev;
      s_d = s_q;
      s_d.st_sync = {s_q.st_sync[0], i_start_sealing_bit};
      s_d.az_sync = {s_q.az_sync[0], i_auto_zero_calibration};
      s_d.st_prev = s_q.st_sync[1];
      s_d.az_prev = s_q.az_sync[1];
      log_we = 1'b0;
      log_wdata = '0;

      // Counters load only from nonvolatile restore; no host path writes them.
      if (i_nv_load) begin
         s_d.cycles = i_nv_cycles;
         s_d.hours = i_nv_hours;
      end else begin
         if (st_rise) begin
            s_d.cycles = s_q.cycles + 1'b1;
         end
         if (s_q.step_cnt == STEP_CYC - 1) begin
            s_d.step_cnt = '0;
            s_d.hours = s_q.hours + 1'b1;
         end else begin
            s_d.step_cnt = s_q.step_cnt + 1'b1;
         end
      end

      // Built-in clock: seconds since an epoch, settable from two paths only.
      if (s_q.tick_cnt == TICK_CYC - 1) begin
         s_d.tick_cnt = '0;
         s_d.now = s_q.now + 1'b1;
      end else begin
         s_d.tick_cnt = s_q.tick_cnt + 1'b1;
      end
      s_d.reject = 1'b0;
      if (i_clk_req_valid && i_clk_req.set) begin
         if (i_clk_req.path == PATH_WEB) begin
            s_d.reject = 1'b1;
         end else begin
            s_d.now = i_clk_req.value;
            s_d.now_valid = 1'b1;
            s_d.tick_cnt = '0;
         end
      end

      // Event capture; error wins, then clock set, then auto zero.
      // A losing event in the same cycle is dropped, since the log takes one entry per cycle.
      if (i_err_strobe) begin
         log_we = 1'b1;
         log_wdata.code = i_err_code;
      end else if (i_clk_req_valid && i_clk_req.set && i_clk_req.path != PATH_WEB) begin
         log_we = 1'b1;
         log_wdata.code = CODE_CLOCK_SET;
      end else if (az_rise) begin
         log_we = 1'b1;
         log_wdata.code = CODE_AUTO_ZERO;
      end
      log_wdata.stamp = s_q.now;
      log_wdata.stamp_valid = s_q.now_valid;
      log_wdata.hours = s_q.hours;
      log_wdata.cycles = s_q.cycles;
      log_wdata.chan = i_chan;
      if (log_we) begin
         s_d.wr_idx = (s_q.wr_idx == LOG_IDX_W'(LOG_DEPTH - 1)) ? '0 : s_q.wr_idx + 1'b1;
         if (s_q.count != LOG_IDX_W'(LOG_DEPTH)) begin
            s_d.count = s_q.count + 1'b1;
         end
      end

      // Readout by age: age 0 is the newest entry.
      s_d.rd = (i_rd_age < s_q.count) ? mem_q[ring_back(s_q.wr_idx, i_rd_age)] : '0;

      // Actual-value output code.
      range = i_range_hi ? RANGE_HI_C : RANGE_LO_C;
      if (i_fault) begin
         s_d.dac = i_fault_level;
      end else if (i_actual_temp[TEMP_W-1]) begin
         s_d.dac = '0;
      end else if (i_actual_temp >= range) begin
         s_d.dac = DAC_FULL;
      end else begin
         prod = i_actual_temp * DAC_FULL;
         s_d.dac = DAC_W'(prod / range);
      end
   end

   // =====================================================================
   // Registers
   // =====================================================================
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Log storage has no reset; readout is gated by the fill count, which reset clears.
   always_ff @(posedge i_core_clk) begin
      if (log_we) begin
         mem_q[s_q.wr_idx] <= log_wdata;
      end
   end

   // Outputs.
   assign o_dac_code = s_q.dac;
   assign o_cycles = s_q.cycles;
   assign o_hours = s_q.hours;
   assign o_time = s_q.now;
   assign o_time_valid = s_q.now_valid;
   assign o_clk_req_reject = s_q.reject;
   assign o_rd_entry = s_q.rd;
   assign o_log_count = s_q.count;

   // =====================================================================
   // Assertions
   // =====================================================================
   sequence seq_web_set;
      i_clk_req_valid && i_clk_req.set && i_clk_req.path == PATH_WEB;
   endsequence

   a_cycle_count_step: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      !i_nv_load && $rose(s_q.st_sync[1]) ##1 !i_nv_load |-> o_cycles == $past(o_cycles) + 1'b1)
      else $error("cycle counter missed a sealing cycle");
   a_cycle_no_drop: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      !i_nv_load |=> o_cycles >= $past(o_cycles))
      else $error("cycle counter went backwards");
   a_hours_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      !i_nv_load && s_q.step_cnt != STEP_CYC - 1 |=> o_hours == $past(o_hours))
      else $error("hours counter changed off step");
   a_hours_step: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      !i_nv_load && s_q.step_cnt == STEP_CYC - 1 |=> o_hours == $past(o_hours) + 1'b1)
      else $error("hours counter missed a step");
   a_web_reject: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      seq_web_set |=> o_clk_req_reject && o_time_valid == $past(o_time_valid))
      else $error("web path set was not rejected");
   a_clock_set: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      i_clk_req_valid && i_clk_req.set && i_clk_req.path != PATH_WEB
      |=> o_time == $past(i_clk_req.value) && o_time_valid)
      else $error("clock set not applied");
   a_log_bound: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      o_log_count <= LOG_IDX_W'(LOG_DEPTH))
      else $error("log count above depth");
   a_fault_level: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      i_fault |=> o_dac_code == $past(i_fault_level))
      else $error("fault level not shown");
   a_full_scale: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      !i_fault && !i_actual_temp[TEMP_W-1] && i_actual_temp >= RANGE_HI_C |=> o_dac_code == DAC_FULL)
      else $error("full scale not reached");
   a_stamp_flag: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      log_we |=> mem_q[$past(s_q.wr_idx)].stamp_valid == $past(o_time_valid)
         && mem_q[$past(s_q.wr_idx)].stamp == $past(o_time))
      else $error("log stamp mismatch");

   // Output code clamps below zero instead of wrapping a negative reading.
   a_zero_clamp: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      !i_fault && i_actual_temp[TEMP_W-1] |=> o_dac_code == '0)
      else $error("negative reading not clamped to zero");

   // Ring pointer wraps at the depth, and the fill count stops there.
   a_log_wrap: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      log_we && s_q.wr_idx == LOG_IDX_W'(LOG_DEPTH - 1) |=> s_q.wr_idx == '0)
      else $error("ring pointer did not wrap at depth");
   a_log_fill: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      log_we && o_log_count != LOG_IDX_W'(LOG_DEPTH)
      |=> o_log_count == $past(o_log_count) + 1'b1)
      else $error("fill count missed a stored event");
   a_log_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      !log_we |=> o_log_count == $past(o_log_count) && s_q.wr_idx == $past(s_q.wr_idx))
      else $error("log moved without an event");

   // Every stored entry freezes the live counters of the cycle in which it was taken.
   a_entry_counts: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      log_we |=> mem_q[$past(s_q.wr_idx)].cycles == $past(o_cycles)
         && mem_q[$past(s_q.wr_idx)].hours == $past(o_hours))
      else $error("entry counters differ from live counters");

   // An error always takes the slot; auto zero is stored only when nothing else competes.
   a_err_priority: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      i_err_strobe |=> mem_q[$past(s_q.wr_idx)].code == $past(i_err_code))
      else $error("error event lost its slot");
   sequence seq_az_edge;
      !s_q.az_sync[1] ##1 s_q.az_sync[1] && !i_err_strobe
         && !(i_clk_req_valid && i_clk_req.set && i_clk_req.path != PATH_WEB);
   endsequence
   a_az_logged: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      seq_az_edge |=> mem_q[$past(s_q.wr_idx)].code == CODE_AUTO_ZERO)
      else $error("auto zero event not logged");

   // Age zero shows the entry written two cycles earlier, even while new writes arrive.
   sequence seq_fresh_write;
      log_we ##1 i_rd_age == '0;
   endsequence
   a_read_newest: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      seq_fresh_write |=> o_rd_entry == $past(log_wdata, 2))
      else $error("newest entry not shown at age zero");

endmodule

// File: logic/usage_log_pkg.sv
// Package for the usage counters and event log block.
// Assumes a single core clock of 125 MHz shared by all users of these types.
package usage_log_pkg;

   // =====================================================================
   // Timing
   // =====================================================================
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned HOUR_STEP_S = 360;
   localparam longint unsigned HOUR_STEP_CYC = longint'(HOUR_STEP_S) * longint'(CLK_HZ);
   localparam int unsigned SEC_CYC = CLK_HZ;

   // =====================================================================
   // Sizes and scaling
   // =====================================================================
   localparam int unsigned LOG_DEPTH = 400;
   localparam int unsigned LOG_IDX_W = 9;
   localparam int unsigned TEMP_W = 16;
   localparam int unsigned DAC_W = 12;
   localparam logic [DAC_W-1:0] DAC_FULL = 12'hFFF;
   localparam logic [TEMP_W-1:0] RANGE_LO_C = 16'h012C;
   localparam logic [TEMP_W-1:0] RANGE_HI_C = 16'h01F4;
   localparam int unsigned CODE_W = 10;
   localparam int unsigned CHAN_W = 3;
   localparam int unsigned TIME_W = 32;
   localparam int unsigned CNT_W = 32;
   localparam logic [CODE_W-1:0] CODE_CLOCK_SET = 10'h000;
   localparam logic [CODE_W-1:0] CODE_AUTO_ZERO = 10'h001;

   // One stored event.
   typedef struct packed {
      logic [TIME_W-1:0] stamp;
      logic stamp_valid;
      logic [CNT_W-1:0] hours;
      logic [CNT_W-1:0] cycles;
      logic [CHAN_W-1:0] chan;
      logic [CODE_W-1:0] code;
   } log_entry_s;

   // Clock set or read request from a host path.
   typedef enum logic [2:0] {
      PATH_FIELDBUS = 3'h1,
      PATH_USB_TOOL = 3'h2,
      PATH_WEB = 3'h4
   } host_path_e;

   typedef struct packed {
      logic set;
      host_path_e path;
      logic [TIME_W-1:0] value;
   } clock_req_s;

endpackage

// File: test/host_clock_partner.sv
// Behavioural fieldbus, tool or web host that issues clock read and set requests.
// Assumes the bench pulses i_go for one cycle, at a rising edge, per request.
`timescale 1ns/100ps
module host_clock_partner
   import usage_log_pkg::*;
(
   // Clock
   input wire logic i_core_clk,
   // Commands from the bench
   input wire logic i_go,
   input wire logic i_set,
   input wire host_path_e i_path,
   input wire logic [TIME_W-1:0] i_value,
   // Request towards the device
   output logic o_valid,
   output clock_req_s o_req
);
   // =====================================================================
   // Request driver
   // =====================================================================
   initial o_valid = 1'b0;
   initial o_req = '0;
   // The payload toggles while idle, so a stale request can never pass for a fresh one.
   always @(posedge i_core_clk) begin
      o_valid <= i_go;
      if (i_go) begin
         o_req <= '{set: i_set, path: i_path, value: i_value};
      end else begin
         o_req <= clock_req_s'(~o_req);
      end
   end
endmodule

// File: test/usage_counters_event_log_bench.sv
// Self-checking bench for the usage counters and event log block.
// Assumes the design package and the host partner model are compiled first.
`timescale 1ns/100ps
module usage_counters_event_log_bench
   import usage_log_pkg::*;
;
   logic clk = 0, rstn = 0, nl = 0, st = 0, az = 0, rhi = 0, flt = 0, es = 0, go = 0, gs = 0;
   logic [CNT_W-1:0] nc = '0, base, h0;
   logic [TEMP_W-1:0] tp = '0;
   logic [DAC_W-1:0] fl = '0, dac;
   logic [CODE_W-1:0] ec = '0;
   logic [CHAN_W-1:0] ch = '0;
   logic [TIME_W-1:0] gv = '0, tim, t0;
   logic [LOG_IDX_W-1:0] age = '0, cnt;
   host_path_e gp = PATH_WEB;
   logic cv, tv, rej, rj;
   clock_req_s cr;
   log_entry_s ent;
   int fails = 0;
   int comparisons = 0;
   int seed = 32'h30D1E7AB;
   usage_counters_event_log #(.STEP_CYC(20), .TICK_CYC(5)) dut_u (.i_core_clk(clk),
      .i_rstn(rstn), .i_nv_load(nl), .i_nv_cycles(nc), .i_nv_hours(nc + 7),
      .i_start_sealing_bit(st), .i_auto_zero_calibration(az), .i_actual_temp(tp),
      .i_range_hi(rhi), .i_fault(flt), .i_fault_level(fl), .i_err_strobe(es),
      .i_err_code(ec), .i_chan(ch), .i_clk_req_valid(cv), .i_clk_req(cr), .i_rd_age(age),
      .o_dac_code(dac), .o_cycles(), .o_hours(), .o_time(tim), .o_time_valid(tv),
      .o_clk_req_reject(rej), .o_rd_entry(ent), .o_log_count(cnt));
   host_clock_partner host_u (.i_core_clk(clk), .i_go(go), .i_set(gs), .i_path(gp),
      .i_value(gv), .o_valid(cv), .o_req(cr));
   // =====================================================================
   // Helpers
   // =====================================================================
   always #4 clk = ~clk;
   // A tolerance of one count covers the seconds tick and rounding of the scale.
   task automatic chk(logic [31:0] got, logic [31:0] exp, bit near = 0);
      logic [31:0] d;
      d = got - exp;
      comparisons++;
      if (d !== 0 && !(near && (d === 1 || d === '1))) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // The age is changed on a clock edge, so callers may end off the edge.
   task automatic rd(int a, logic [CODE_W-1:0] c, logic v);
      @(posedge clk);
      age <= a[LOG_IDX_W-1:0];
      repeat (2) @(posedge clk);
      #1 chk(ent.code, c);
      chk(ent.stamp_valid, v);
   endtask
   task automatic ev(logic [CODE_W-1:0] c);
      @(posedge clk);
      es <= 1'b1;
      ec <= c;
      ch <= CHAN_W'($random(seed));
      @(posedge clk);
      es <= 1'b0;
   endtask
   task automatic host(host_path_e p, logic s, logic [TIME_W-1:0] v);
      @(posedge clk);
      gp <= p;
      gs <= s;
      gv <= v;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      rj = 0;
      repeat (4) begin
         @(posedge clk);
         #1 rj |= rej;
      end
   endtask
   function automatic logic [31:0] exp_dac(logic signed [TEMP_W-1:0] t, logic h);
      int r = h ? 500 : 300;
      if (t <= 0) return 0;
      if (t >= r) return 32'hFFF;
      return t * 4095 / r;
   endfunction
   task automatic results;
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // =====================================================================
   // Watchdog
   // =====================================================================
   // The tests need about 800 cycles; ten thousand leaves ample margin.
   initial begin
      #(8 * 10000) fails++;
      results();
   end
   // =====================================================================
   // Main sequence
   // =====================================================================
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      base = $random(seed);
      nl <= 1'b1;
      nc <= base;
      @(posedge clk);
      nl <= 1'b0;
      ev(10'h3FF);
      rd(0, 10'h3FF, 1'b0);
      host(PATH_WEB, 1'b1, 32'h1234);
      chk({rj, tv}, 2'b10);
      host(PATH_WEB, 1'b0, 32'h0);
      chk(rj, 1'b0);
      host(PATH_FIELDBUS, 1'b1, 32'h5000);
      chk(tim, 32'h5000, 1);
      // The first set is stored with the clock state it replaces, so its stamp is invalid.
      rd(0, CODE_CLOCK_SET, 1'b0);
      host(PATH_USB_TOOL, 1'b1, 32'h9000);
      chk({rj, tv}, 2'b01);
      @(posedge clk);
      az <= 1'b1;
      repeat (6) @(posedge clk);
      az <= 1'b0;
      rd(0, CODE_AUTO_ZERO, 1'b1);
      $display("test clock and event codes done");
      @(posedge clk);
      for (int k = 0; k < 5; k++) begin
         st <= 1'b1;
         repeat (3) @(posedge clk);
         st <= 1'b0;
         repeat (3) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      #1 chk(dut_u.o_cycles, base + 5);
      h0 = dut_u.o_hours;
      repeat (200) @(posedge clk);
      #1 chk(dut_u.o_hours - h0, 10, 1);
      t0 = tim;
      ev(10'h2AA);
      rd(0, 10'h2AA, 1'b1);
      chk(ent.stamp, t0, 1);
      chk(ent.cycles, base + 5);
      chk(ent.chan, ch);
      chk(ent.hours, h0 + 10, 1);
      $display("test counters and stamp done");
      @(posedge clk);
      for (int i = 0; i < 401; i++) begin
         es <= 1'b1;
         ec <= 10'h100 + i[9:0];
         @(posedge clk);
      end
      es <= 1'b0;
      rd(399, 10'h101, 1'b1);
      rd(0, 10'h290, 1'b1);
      rd(400, 10'h000, 1'b0);
      chk(cnt, 400);
      $display("test ring log done");
      for (int i = 0; i < 24; i++) begin
         @(posedge clk);
         tp <= (i < 4) ? TEMP_W'(i * 200 - 5) : TEMP_W'($random(seed) % 600);
         rhi <= i[0];
         flt <= (i % 5 == 4);
         fl <= DAC_W'($random(seed));
         repeat (3) @(posedge clk);
         #1 chk(dac, flt ? 32'(fl) : exp_dac(tp, rhi), !flt);
      end
      $display("test output code done");
      results();
   end
endmodule
